//--- pkg/dac_params.svh
// offsets, field positions, reset values and masks of the active-channel block
`ifndef DAC_PARAMS_SVH
`define DAC_PARAMS_SVH
// ---------------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------------
`define DAC_IDX_ACTIVE   7'h30
`define DAC_IDX_DBASE    7'h34
`define DAC_IDX_WBASE    7'h38
`define DAC_IDX_CHSEL    7'h3F
`define DAC_IDX_CTLA     7'h40
`define DAC_IDX_CTLB     7'h44
`define DAC_ADDR_W       9
// ---------------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------------
`define DAC_NUM_CH       6
`define DAC_CTLA_CHANNEL_SOFT_RESET   0
`define DAC_CTLA_ENABLE  1
`define DAC_CTLB_MASK    32'h03C01F7F
`define DAC_CTLB_TACT_LO 22
`define DAC_CTLB_LVL_LO  5
`define DAC_TACT_BEAT    2'h2
`define DAC_TACT_RSVD    2'h1
`define DAC_BASE_RST     32'h00000000
`define DAC_CTLB_RST     32'h00000000
`define DAC_ENTRY_SHIFT  4
`define DAC_RESP_OKAY    2'h0
`define DAC_RESP_SLVERR  2'h2
`endif

//--- pkg/dac_pkg.sv
// types shared by the active-channel block
package dac_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_WB, ST_FETCH, ST_DESC, ST_RUN} dac_state_e;
  typedef logic [2:0] dac_chan_t;
endpackage : dac_pkg

//--- hdl/dac_chan_mem.sv
// per-channel control-B storage with registered read port
`timescale 1ns/1ps
`default_nettype none
`include "dac_params.svh"
module dac_chan_mem
  import dac_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  // write and clear
  input  wire logic        wr_en_in,
  input  wire dac_chan_t   wr_idx_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        clr_en_in,
  input  wire dac_chan_t   clr_idx_in,
  // read
  input  wire dac_chan_t   rd_idx_in,
  output logic [31:0]      rd_data_out,
  output logic [11:0]      lvl_flat_out,
  output logic [11:0]      tact_flat_out
);
  logic [31:0] mem_reg [`DAC_NUM_CH];

  always_ff @(posedge core_clk_in)
  begin
    for (int i = 0; i < `DAC_NUM_CH; i++)
    begin
      if (srst_in || (clr_en_in && clr_idx_in == 3'(i)))
        mem_reg[i] <= `DAC_CTLB_RST;
      else if (wr_en_in && wr_idx_in == 3'(i))
        mem_reg[i] <= wr_data_in & `DAC_CTLB_MASK;
    end
    if (srst_in)
      rd_data_out <= `DAC_CTLB_RST;
    else
      rd_data_out <= (rd_idx_in < 3'(`DAC_NUM_CH)) ? mem_reg[rd_idx_in] : 32'h0;
  end

  always_comb
  begin
    for (int i = 0; i < `DAC_NUM_CH; i++)
    begin
      lvl_flat_out[2*i+:2]  = mem_reg[i][`DAC_CTLB_LVL_LO+:2];
      tact_flat_out[2*i+:2] = mem_reg[i][`DAC_CTLB_TACT_LO+:2];
    end
  end
endmodule : dac_chan_mem
`default_nettype wire

//--- hdl/dac_active_chan.sv
// active channel status, base addresses, channel select and per-channel control
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dac_params.svh"
module dac_active_chan
  import dac_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk_in,
  input  wire logic                  srst_in,
  // axi4-lite write
  input  wire logic [`DAC_ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                  s_axi_awvalid_in,
  output logic                       s_axi_awready_out,
  input  wire logic [31:0]           s_axi_wdata_in,
  input  wire logic [3:0]            s_axi_wstrb_in,
  input  wire logic                  s_axi_wvalid_in,
  output logic                       s_axi_wready_out,
  output logic [1:0]                 s_axi_bresp_out,
  output logic                       s_axi_bvalid_out,
  input  wire logic                  s_axi_bready_in,
  // axi4-lite read
  input  wire logic [`DAC_ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic                  s_axi_arvalid_in,
  output logic                       s_axi_arready_out,
  output logic [31:0]                s_axi_rdata_out,
  output logic [1:0]                 s_axi_rresp_out,
  output logic                       s_axi_rvalid_out,
  input  wire logic                  s_axi_rready_in,
  // system memory port
  output logic                       mem_req_out,
  output logic                       mem_we_out,
  output logic [31:0]                mem_addr_out,
  output logic [31:0]                mem_wdata_out,
  input  wire logic                  mem_ack_in,
  input  wire logic [31:0]           mem_rdata_in,
  // channel triggers and datapath progress
  input  wire logic [`DAC_NUM_CH-1:0] chan_trig_in,
  input  wire logic                  beat_done_in,
  output logic [`DAC_NUM_CH-1:0]     chan_enable_out
);
  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic logic [5:0] reg_sel(input logic [`DAC_ADDR_W-1:0] a);
    reg_sel = {a[8:2] == `DAC_IDX_CTLB, a[8:2] == `DAC_IDX_CTLA, a[8:2] == `DAC_IDX_CHSEL,
               a[8:2] == `DAC_IDX_WBASE, a[8:2] == `DAC_IDX_DBASE, a[8:2] == `DAC_IDX_ACTIVE};
  endfunction : reg_sel

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    integer b;
    merge = old;
    for (b = 0; b < 4; b++)
      if (strb[b])
        merge[8*b+:8] = nw[8*b+:8];
  endfunction : merge

  function automatic logic [31:0] chan_addr(input logic [31:0] base, input logic [4:0] id);
    chan_addr = base + {23'h0, id, 4'h0};
  endfunction : chan_addr

  // highest level wins, lowest index breaks a tie
  function automatic logic [3:0] pick_winner(input logic [5:0] pend, input logic [11:0] lvls);
    integer l;
    integer c;
    pick_winner = 4'h0;
    for (l = 0; l < 4; l++)
      for (c = 5; c >= 0; c--)
        if (pend[c] && lvls[2*c+:2] == 2'(l))
          pick_winner = {1'b1, 3'(c)};
  endfunction : pick_winner

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  dac_state_e  state_reg, state_next;
  logic        aw_full_reg, w_full_reg, awready_reg, wready_reg, bvalid_reg;
  logic        arready_reg, rvalid_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg, wdata_reg;
  logic [3:0]  wstrb_reg;
  logic [`DAC_ADDR_W-1:0] awaddr_reg;
  logic [31:0] dbase_reg, wbase_reg;
  dac_chan_t   chan_sel_reg;
  logic [5:0]  enable_reg, enable_next, dis_pend_reg, dis_pend_next;
  logic        channel_soft_reset_pend_reg;
  dac_chan_t   channel_soft_reset_ch_reg;
  logic [15:0] count_reg;
  logic        busy_reg, regrant_reg;
  logic [4:0]  active_id_reg, wb_id_reg;
  logic [1:0]  active_lvl_reg;
  logic [3:0]  lvl_flags_reg;
  logic        mem_req_reg, mem_we_reg;
  logic [31:0] mem_addr_reg, mem_wdata_reg;

  // -------------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------------
  wire         aw_take  = s_axi_awvalid_in && awready_reg;
  wire         w_take   = s_axi_wvalid_in && wready_reg;
  wire         ar_take  = s_axi_arvalid_in && arready_reg;
  wire         wr_do    = aw_full_reg && w_full_reg && !bvalid_reg;
  wire [5:0]   wsel     = reg_sel(awaddr_reg);
  wire [5:0]   rsel     = reg_sel(s_axi_araddr_in);
  wire         wr_dbase = wr_do && wsel[1];
  wire         wr_wbase = wr_do && wsel[2];
  wire         wr_chsel = wr_do && wsel[3] && wstrb_reg[0];
  wire         wr_ctla  = wr_do && wsel[4] && wstrb_reg[0];
  wire         wr_ctlb  = wr_do && wsel[5];
  wire         aw_full_next = (aw_full_reg || aw_take) && !wr_do;
  wire         w_full_next  = (w_full_reg || w_take) && !wr_do;
  wire         bvalid_next  = wr_do || (bvalid_reg && !s_axi_bready_in);
  wire         rvalid_next  = ar_take || (rvalid_reg && !s_axi_rready_in);

  // -------------------------------------------------------------------
  // per-channel storage
  // -------------------------------------------------------------------
  wire [31:0]  ctlb_rd;
  wire [11:0]  lvl_flat;
  wire [11:0]  tact_flat;
  wire         channel_soft_reset_ok;
  wire [31:0]  ctlb_merged = merge(ctlb_rd, wdata_reg, wstrb_reg);
  // a reserved trigger action code leaves the field as it was
  wire [31:0]  ctlb_wr = (ctlb_merged[`DAC_CTLB_TACT_LO+:2] == `DAC_TACT_RSVD) ?
                         {ctlb_merged[31:24], ctlb_rd[`DAC_CTLB_TACT_LO+:2], ctlb_merged[21:0]} :
                         ctlb_merged;

  dac_chan_mem u_mem (
    .core_clk_in   (core_clk_in),
    .srst_in       (srst_in),
    .wr_en_in      (wr_ctlb),
    .wr_idx_in     (chan_sel_reg),
    .wr_data_in    (ctlb_wr),
    .clr_en_in     (channel_soft_reset_ok),
    .clr_idx_in    (chan_sel_reg),
    .rd_idx_in     (chan_sel_reg),
    .rd_data_out   (ctlb_rd),
    .lvl_flat_out  (lvl_flat),
    .tact_flat_out (tact_flat)
  );

  // -------------------------------------------------------------------
  // active channel engine
  // -------------------------------------------------------------------
  wire [5:0]   pend_vec   = chan_trig_in & enable_reg & ~dis_pend_reg;
  wire [3:0]   winner     = pick_winner(pend_vec, lvl_flat);
  wire [2:0]   act_ch     = active_id_reg[2:0];
  wire [1:0]   act_tact   = tact_flat[2*act_ch+:2];
  // per-beat triggering needs the trigger present on every beat
  wire         beat_ok    = beat_done_in && (act_tact != `DAC_TACT_BEAT || chan_trig_in[act_ch]);
  wire         in_run     = state_reg == ST_RUN;
  wire         abort      = in_run && beat_done_in && dis_pend_reg[act_ch];
  wire         run_end    = abort || !enable_reg[act_ch] || (beat_ok && count_reg == 16'h0001);
  // clear storage at the same edge the busy bit rises, so a read right after sees it done
  assign channel_soft_reset_ok = wr_ctla && wdata_reg[`DAC_CTLA_CHANNEL_SOFT_RESET] && !enable_reg[chan_sel_reg]
                    && !channel_soft_reset_pend_reg;
  wire         grant      = state_reg == ST_IDLE && winner[3];

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (grant)
          state_next = !busy_reg ? ST_FETCH :
                       (winner[2:0] == act_ch) ? ST_RUN : ST_WB;
      ST_WB:
        if (mem_ack_in)
          state_next = regrant_reg ? ST_FETCH : ST_IDLE;
      ST_FETCH:
        if (mem_ack_in)
          state_next = (mem_rdata_in[15:0] == 16'h0) ? ST_DESC : ST_RUN;
      ST_DESC:
        if (mem_ack_in)
          state_next = ST_RUN;
      ST_RUN:
        if (run_end)
          state_next = ST_WB;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_comb
  begin
    enable_next   = enable_reg;
    dis_pend_next = dis_pend_reg;
    for (int c = 0; c < `DAC_NUM_CH; c++)
    begin
      if (wr_ctla && chan_sel_reg == 3'(c))
      begin
        if (wdata_reg[`DAC_CTLA_ENABLE])
        begin
          enable_next[c]   = 1'b1;
          dis_pend_next[c] = 1'b0;
        end
        else if (in_run && act_ch == 3'(c) && enable_reg[c])
          dis_pend_next[c] = 1'b1;
        else
          enable_next[c] = 1'b0;
      end
      if (abort && act_ch == 3'(c))
      begin
        enable_next[c]   = 1'b0;
        dis_pend_next[c] = 1'b0;
      end
      if (channel_soft_reset_pend_reg && channel_soft_reset_ch_reg == 3'(c))
        dis_pend_next[c] = 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      bresp_reg   <= `DAC_RESP_OKAY;
      rresp_reg   <= `DAC_RESP_OKAY;
      rdata_reg   <= 32'h0;
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awready_reg <= !aw_full_next && !bvalid_next;
      wready_reg  <= !w_full_next && !bvalid_next;
      bvalid_reg  <= bvalid_next;
      arready_reg <= !rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (aw_take)
        awaddr_reg <= s_axi_awaddr_in;
      if (w_take)
      begin
        wdata_reg <= s_axi_wdata_in;
        wstrb_reg <= s_axi_wstrb_in;
      end
      if (wr_do)
        bresp_reg <= (|wsel) ? `DAC_RESP_OKAY : `DAC_RESP_SLVERR;
      if (ar_take)
      begin
        rresp_reg <= (|rsel) ? `DAC_RESP_OKAY : `DAC_RESP_SLVERR;
        // unused bits stay zero in every read word
        rdata_reg <= ({32{rsel[0]}} & {busy_reg ? count_reg : count_reg, busy_reg, 2'b00,
                                        active_id_reg, 4'h0, lvl_flags_reg})
                   | ({32{rsel[1]}} & dbase_reg)
                   | ({32{rsel[2]}} & wbase_reg)
                   | ({32{rsel[3]}} & {29'h0, chan_sel_reg})
                   | ({32{rsel[4]}} & {30'h0, enable_reg[chan_sel_reg],
                                       channel_soft_reset_pend_reg && channel_soft_reset_ch_reg == chan_sel_reg})
                   | ({32{rsel[5]}} & ctlb_rd);
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      dbase_reg      <= `DAC_BASE_RST;
      wbase_reg      <= `DAC_BASE_RST;
      chan_sel_reg   <= 3'h0;
      enable_reg     <= 6'h00;
      dis_pend_reg   <= 6'h00;
      channel_soft_reset_pend_reg <= 1'b0;
      channel_soft_reset_ch_reg   <= 3'h0;
    end
    else
    begin
      if (wr_dbase)
        dbase_reg <= merge(dbase_reg, wdata_reg, wstrb_reg);
      if (wr_wbase)
        wbase_reg <= merge(wbase_reg, wdata_reg, wstrb_reg);
      if (wr_chsel)
        chan_sel_reg <= wdata_reg[2:0];
      enable_reg   <= enable_next;
      dis_pend_reg <= dis_pend_next;
      // the reset takes one cycle; the bit reads one throughout it
      channel_soft_reset_pend_reg <= channel_soft_reset_ok;
      if (channel_soft_reset_ok)
        channel_soft_reset_ch_reg <= chan_sel_reg;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      state_reg      <= ST_IDLE;
      count_reg      <= 16'h0;
      busy_reg       <= 1'b0;
      regrant_reg    <= 1'b0;
      active_id_reg  <= 5'h00;
      wb_id_reg      <= 5'h00;
      active_lvl_reg <= 2'h0;
      lvl_flags_reg  <= 4'h0;
    end
    else
    begin
      state_reg <= state_next;
      if (grant && !(busy_reg && winner[2:0] == act_ch))
      begin
        active_id_reg  <= {2'b00, winner[2:0]};
        active_lvl_reg <= lvl_flat[2*winner[2:0]+:2];
        wb_id_reg      <= active_id_reg;
        regrant_reg    <= 1'b1;
      end
      else if (in_run && run_end)
      begin
        wb_id_reg   <= active_id_reg;
        regrant_reg <= 1'b0;
      end
      if (state_reg == ST_WB && mem_ack_in)
        busy_reg <= 1'b0;
      if (state_reg == ST_FETCH && mem_ack_in)
      begin
        busy_reg  <= 1'b1;
        count_reg <= mem_rdata_in[15:0];
      end
      if (state_reg == ST_DESC && mem_ack_in)
        count_reg <= mem_rdata_in[31:16];
      if (in_run && beat_ok && !abort)
        count_reg <= count_reg - 16'h0001;
      for (int l = 0; l < 4; l++)
      begin
        lvl_flags_reg[l] <= (busy_reg && state_reg != ST_IDLE && active_lvl_reg == 2'(l)) ||
                            (|(pend_vec & {lvl_flat[10+:2] == 2'(l), lvl_flat[8+:2] == 2'(l),
                                           lvl_flat[6+:2] == 2'(l), lvl_flat[4+:2] == 2'(l),
                                           lvl_flat[2+:2] == 2'(l), lvl_flat[0+:2] == 2'(l)}));
      end
    end
  end

  // memory request stands from the entry to a memory state until its ack
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      mem_req_reg   <= 1'b0;
      mem_we_reg    <= 1'b0;
      mem_addr_reg  <= 32'h0;
      mem_wdata_reg <= 32'h0;
    end
    else
    begin
      mem_req_reg   <= state_next == ST_WB || state_next == ST_FETCH || state_next == ST_DESC;
      mem_we_reg    <= state_next == ST_WB;
      mem_wdata_reg <= {16'h0, (in_run && beat_ok && !abort) ? count_reg - 16'h0001 : count_reg};
      mem_addr_reg  <= (state_next == ST_WB) ?
                       chan_addr(wbase_reg, (state_reg == ST_IDLE) ? active_id_reg : wb_id_reg) :
                       (state_next == ST_DESC) ? chan_addr(dbase_reg, active_id_reg) :
                       chan_addr(wbase_reg, (grant && !busy_reg) ? {2'b00, winner[2:0]} : active_id_reg);
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign s_axi_awready_out = awready_reg;
  assign s_axi_wready_out  = wready_reg;
  assign s_axi_bvalid_out  = bvalid_reg;
  assign s_axi_bresp_out   = bresp_reg;
  assign s_axi_arready_out = arready_reg;
  assign s_axi_rvalid_out  = rvalid_reg;
  assign s_axi_rresp_out   = rresp_reg;
  assign s_axi_rdata_out   = rdata_reg;
  assign mem_req_out       = mem_req_reg;
  assign mem_we_out        = mem_we_reg;
  assign mem_addr_out      = mem_addr_reg;
  assign mem_wdata_out     = mem_wdata_reg;
  assign chan_enable_out   = enable_reg;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  property p_wb_clears_busy;
    state_reg == ST_WB && mem_ack_in |=> !busy_reg;
  endproperty
  a_wb_clears_busy: assert property (p_wb_clears_busy) else $error("busy kept after write-back");
  property p_fetch_sets_busy;
    state_reg == ST_FETCH && mem_ack_in |=> busy_reg && count_reg == $past(mem_rdata_in[15:0]);
  endproperty
  a_fetch_sets_busy: assert property (p_fetch_sets_busy) else $error("fetch did not load");
  property p_id_on_grant;
    !$stable(active_id_reg) |-> $past(grant);
  endproperty
  a_id_on_grant: assert property (p_id_on_grant) else $error("id changed without grant");
  property p_wb_payload;
    mem_req_out && mem_we_out |-> mem_wdata_out == {16'h0, count_reg} && state_reg == ST_WB;
  endproperty
  a_wb_payload: assert property (p_wb_payload) else $error("write-back word wrong");
  property p_channel_soft_reset_ignored;
    wr_ctla && wdata_reg[0] && enable_reg[chan_sel_reg] && !channel_soft_reset_pend_reg |=> !channel_soft_reset_pend_reg;
  endproperty
  a_channel_soft_reset_ignored: assert property (p_channel_soft_reset_ignored) else $error("reset of enabled channel");
  property p_channel_soft_reset_self_clear;
    channel_soft_reset_pend_reg |=> !channel_soft_reset_pend_reg ##1 u_mem.rd_data_out == 32'h0 || chan_sel_reg != $past(channel_soft_reset_ch_reg, 2);
  endproperty
  a_channel_soft_reset_self_clear: assert property (p_channel_soft_reset_self_clear) else $error("soft reset stuck");
  property p_enable_set;
    wr_ctla && wdata_reg[1] |=> enable_reg[$past(chan_sel_reg)];
  endproperty
  a_enable_set: assert property (p_enable_set) else $error("enable not set");
  property p_enable_hold;
    in_run && dis_pend_reg[act_ch] && !beat_done_in |=> enable_reg[$past(act_ch)];
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable dropped mid-burst");
  property p_desc_addr;
    mem_req_out && state_reg == ST_DESC |-> mem_addr_out == chan_addr(dbase_reg, active_id_reg);
  endproperty
  a_desc_addr: assert property (p_desc_addr) else $error("descriptor address wrong");
  logic [5:0] rsel_q;
  property p_bus_answer;
    ar_take |=> s_axi_rvalid_out ##0 (rsel_q != 6'h0 || s_axi_rresp_out == `DAC_RESP_SLVERR);
  endproperty
  always_ff @(posedge core_clk_in)
  begin
    rsel_q <= rsel;
  end
  a_bus_answer: assert property (p_bus_answer) else $error("read answer wrong");

  c_writeback: cover property (state_reg == ST_WB && mem_ack_in && regrant_reg);
  c_desc_load: cover property (state_reg == ST_DESC && mem_ack_in);
  c_abort:     cover property (abort);
endmodule : dac_active_chan
`default_nettype wire

//--- tb/dac_mem_model.sv
// memory partner: answers the block's memory port after a chosen latency
`timescale 1ns/1ps
`default_nettype none
module dac_mem_model (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  // memory port
  input  wire logic        mem_req_in,
  input  wire logic        mem_we_in,
  input  wire logic [31:0] mem_addr_in,
  input  wire logic [31:0] mem_wdata_in,
  input  wire logic [1:0]  lat_in,
  output var logic         mem_ack_out,
  output var logic [31:0]  mem_rdata_out
);
  // unwritten entries: write-back count 0, descriptor count 3
  localparam logic [31:0] FILL = 32'h00030000;
  logic [31:0] ram [logic [31:0]];
  int          cnt;
  always @(posedge core_clk_in)
  begin
    mem_ack_out   <= 1'b0;
    // data line is not held outside an answer
    mem_rdata_out <= srst_in ? 32'h0 : ~mem_rdata_out;
    cnt           <= (mem_req_in && !mem_ack_out) ? cnt + 1 : 0;
    if (!srst_in && mem_req_in && !mem_ack_out && cnt >= lat_in)
    begin
      mem_ack_out <= 1'b1;
      cnt         <= 0;
      if (mem_we_in)
        ram[mem_addr_in] = mem_wdata_in;
      else
        mem_rdata_out <= ram.exists(mem_addr_in) ? ram[mem_addr_in] : FILL;
    end
  end
endmodule : dac_mem_model
`default_nettype wire

//--- tb/dac_active_chan_tb_top.sv
// self-checking bench for the active-channel block
`timescale 1ns/1ps
`default_nettype none
`include "dac_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module dac_active_chan_tb_top import dac_pkg::*;;
  logic        clk = 0, srst = 1, awv = 0, wv = 0, arv = 0, bd = 0;
  logic [8:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, x = 0, st = 32'h05F9F21F, d = 0, wb = 0;
  logic [31:0] e [6] = '{default: 32'h0};
  logic [5:0]  trig = 0, en;
  logic [1:0]  lat = 0, r, br_, rr_;
  logic        awr, wr_, bv, arr, rv, mrq, mwe, mak;
  logic [31:0] rdat, ma, mwd, mrd;
  int          n_fail = 0, compares = 0, cyc = 0, k;
  dac_active_chan uut (.core_clk_in(clk), .srst_in(srst),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_),
    .s_axi_bresp_out(br_), .s_axi_bvalid_out(bv), .s_axi_bready_in(1'b1),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr_), .s_axi_rvalid_out(rv), .s_axi_rready_in(1'b1),
    .mem_req_out(mrq), .mem_we_out(mwe), .mem_addr_out(ma), .mem_wdata_out(mwd),
    .mem_ack_in(mak), .mem_rdata_in(mrd), .chan_trig_in(trig), .beat_done_in(bd), .chan_enable_out(en));
  dac_mem_model u_mem (.core_clk_in(clk), .srst_in(srst), .mem_req_in(mrq), .mem_we_in(mwe),
    .mem_addr_in(ma), .mem_wdata_in(mwd), .lat_in(lat), .mem_ack_out(mak), .mem_rdata_out(mrd));
  function automatic logic [31:0] rnd();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction : rnd
  // bready and rready stay high, so only valids move
  task automatic wr(input logic [8:0] a, input logic [31:0] v);
    awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_) wv <= 1'b0;
      if (bv) break;
    end
    r = br_;
  endtask : wr
  task automatic rd(input logic [8:0] a);
    ara <= a; arv <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    d = rdat; r = rr_;
  endtask : rd
  task automatic tally_and_finish();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial forever #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (k = 0; k < 6; k++)
    begin
      rd((k == 3) ? 9'h0FC : 9'(9'h0C0 + 16 * k));
      `CHK(d, 32'h0)
      `CHK(r, `DAC_RESP_OKAY)
    end
    for (k = 0; k < 2; k++)
    begin
      // software keeps bases 128-bit aligned
      x = rnd() & 32'hFFFFFFF0;
      wr(9'h0D0 + {k[4:0], 4'h0}, x);
      rd(9'h0D0 + {k[4:0], 4'h0});
      `CHK(d, x)
    end
    wb = x;
    wr(9'h004, rnd());
    `CHK(r, `DAC_RESP_SLVERR)
    rd(9'h0E0);
    `CHK(d, wb)
    $display("test bases done");
    for (k = 0; k < 12; k++)
    begin
      x = rnd() & `DAC_CTLB_MASK & 32'hFF3FFFFF;
      x[23:22] = (k < 6) ? k[1:0] : `DAC_TACT_RSVD;
      wr(9'h0FC, k % 6);
      wr(9'h110, x);
      if (x[23:22] == `DAC_TACT_RSVD) x[23:22] = e[k % 6][23:22];
      e[k % 6] = x;
    end
    for (k = 0; k < 6; k++)
    begin
      wr(9'h0FC, k);
      rd(9'h110);
      `CHK(d, e[k])
    end
    $display("test channels done");
    wr(9'h0FC, 3);
    wr(9'h100, 2);
    `CHK(en, 6'h08)
    wr(9'h100, 3);
    rd(9'h110);
    `CHK(d, e[3])
    wr(9'h100, 0);
    wr(9'h100, 1);
    rd(9'h110);
    `CHK(d, 32'h0)
    $display("test soft reset done");
    x = rnd();
    lat <= x[1:0];
    wr(9'h0FC, 4);
    wr(9'h100, 2);
    trig <= 6'h10;
    d = 32'h0;
    for (k = 0; k < 60 && !d[15]; k++)
      rd(9'h0C0);
    `CHK(d[15:8], 8'h84)
    // busy rises at the write-back fetch; the descriptor count lands a few cycles later
    repeat (8) @(posedge clk);
    rd(9'h0C0);
    `CHK(d[31:16], 16'h0003)
    `CHK(d[e[4][6:5]], 1'b1)
    trig <= 6'h00;
    repeat (3)
    begin
      @(posedge clk);
      bd <= 1'b1;
      @(posedge clk);
      bd <= 1'b0;
    end
    for (k = 0; k < 60 && d[15]; k++)
      rd(9'h0C0);
    `CHK(d[15], 1'b0)
    `CHK(u_mem.ram.exists(wb + 32'h40), 1)
    `CHK(u_mem.ram[wb + 32'h40], 32'h0)
    $display("test active done");
    tally_and_finish();
  end
endmodule : dac_active_chan_tb_top
`default_nettype wire
